// >>> msi_vpd_consts.vh
// Constants for the capability register bank: offsets, fields, reset values.
// Assumes inclusion by bare name from each design file.
`ifndef MSI_VPD_CONSTS_VH
`define MSI_VPD_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define OFS_MSG_CTRL      8'h4C
`define OFS_MSG_ADDR      8'h50
`define OFS_MSG_UADDR     8'h54
`define OFS_MSG_DATA      8'h58
`define OFS_PD_CTRL       8'h5C
`define OFS_PD_DATA       8'h60
`define OFS_VEND_HDR      8'h64
`define OFS_TEST0         8'h68
`define OFS_IRQ_STATUS    8'h80
`define OFS_IRQ_MASK      8'h84
`define OFS_MSI_TRIGGER   8'h88

// ----------------------------------------------------------------------------
// Fixed identifiers and fields.
// ----------------------------------------------------------------------------
`define MSI_CAP_ID        8'h05
`define MSI_NEXT_PTR      8'h64
`define PD_CAP_ID         8'h03
`define PD_NEXT_PTR       8'h64
`define VEND_CAP_ID       8'h09
`define VEND_NEXT_PTR     8'hB0
`define VEND_LENGTH       16'h0034
`define BIT_MSI_EN        16
`define BIT_ADDR64        23
`define BIT_PD_FLAG       31
`define PD_ADDR_HI        23
`define PD_ADDR_LO        18
`define MME_HI            22
`define MME_LO            20

// ----------------------------------------------------------------------------
// Reset values and interrupt status bits.
// ----------------------------------------------------------------------------
`define TEST0_RESET       32'h04001060
`define ZERO32            32'h00000000
`define IRQ_W             2
`define IRQ_PD_DONE       0
`define IRQ_MSI_SENT      1

`endif

// >>> pd_eeprom_seq.v
// EEPROM access sequencer for the product data table.
// Assumes the EEPROM agent answers each started cycle with a one-cycle done.
`timescale 1ns/1ns
`include "msi_vpd_consts.vh"

module pd_eeprom_seq (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // Start request from the register bank.
  input  wire        start,
  input  wire        write_op,
  input  wire [5:0]  addr,
  input  wire [31:0] wdata,
  // EEPROM agent.
  output reg         ee_req,
  output reg         ee_write,
  output reg  [5:0]  ee_addr,
  output reg  [31:0] ee_wdata,
  input  wire        ee_done,
  input  wire [31:0] ee_rdata,
  // Completion toward the register bank.
  output reg         busy,
  output reg         finish,
  output reg  [31:0] rdata
);

  // --------------------------------------------------------------------------
  // Request and completion.
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_req   <= 1'b0;
      ee_write <= 1'b0;
      ee_addr  <= 6'h00;
      ee_wdata <= `ZERO32;
      busy     <= 1'b0;
      finish   <= 1'b0;
      rdata    <= `ZERO32;
    end else begin
      finish <= 1'b0;
      if (!busy && start) begin
        busy     <= 1'b1;
        ee_req   <= 1'b1;
        ee_write <= write_op;
        ee_addr  <= addr;
        ee_wdata <= wdata;
      end else if (busy && ee_done) begin
        busy   <= 1'b0;
        ee_req <= 1'b0;
        finish <= 1'b1;
        if (!ee_write) begin
          rdata <= ee_rdata;
        end
      end
    end
  end

endmodule // pd_eeprom_seq

// >>> msi_sender.v
// Interrupt message issuer: one memory write per service request.
// Assumes the fabric answers msg_valid with a one-cycle msg_ack.
`timescale 1ns/1ns
`include "msi_vpd_consts.vh"

module msi_sender (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // Request and settings.
  input  wire        request,
  input  wire        enable,
  input  wire [63:0] target,
  input  wire [15:0] payload,
  // Fabric side.
  output reg         msg_valid,
  output reg  [63:0] msg_addr,
  output reg  [31:0] msg_data,
  input  wire        msg_ack,
  // Legacy pin and completion.
  output reg         intx_assert,
  output reg         sent
);

  // --------------------------------------------------------------------------
  // Message or legacy signalling.
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_valid   <= 1'b0;
      msg_addr    <= 64'h0000000000000000;
      msg_data    <= `ZERO32;
      intx_assert <= 1'b0;
      sent        <= 1'b0;
    end else begin
      sent <= 1'b0;
      // [R3] Messages replace legacy pin.
      intx_assert <= request && !enable;
      // [R2] Gated by enable.
      if (!msg_valid && request && enable) begin
        msg_valid <= 1'b1;
        // [R5] Aligned low address.
        msg_addr  <= {target[63:2], 2'b00};
        // [R7] Payload from data field.
        msg_data  <= {16'h0000, payload};
      end else if (msg_valid && msg_ack) begin
        msg_valid <= 1'b0;
        sent      <= 1'b1;
      end
    end
  end

endmodule // msi_sender

// >>> msi_product_data_capability_header_regs.v
// Capability register bank: interrupt message, product data, vendor, test.
// Assumes an APB master on pclk and EEPROM and fabric agents outside.
//
// Contract
// [R1] The message capability header reads identifier 05h in its low byte.
// [R2] With the message enable bit clear, no interrupt message is sent.
// [R3] With the enable set, service goes by message and the legacy pin stays low.
// [R4] The 64-bit capable bit 23 is read-only and reads 1.
// [R5] Address bits 31:2 are writable, reset zero, and give the aligned target.
// [R6] The upper address register is writable, reset zero, and gives the high half.
// [R7] The 16-bit payload is sent with each message; one vector, enable field ignored.
// [R8] The product data header reads identifier 03h and next pointer 64h.
// [R9] The product data address field, bits 23:18, selects the table word.
// [R10] Writing flag 0 starts a read; the flag stays 0 and becomes 1 on completion.
// [R11] Writing flag 1 starts a write; the flag stays 1 and becomes 0 on completion.
// [R12] Software polls the flag before the next access or use of data.
// [R13] The data register carries the word written or the word read back.
// [R14] The vendor header reads identifier 09h.
// [R15] The vendor header reads next pointer B0h.
// [R16] The vendor header reads length 0034h in bits 31:16.
// [R17] The test control word resets to 04001060h and is read-write.
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`include "msi_vpd_consts.vh"

module msi_product_data_capability_header_regs (
  // APB clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Port service request.
  input  wire        service_req,
  // Interrupt message fabric.
  output reg         msg_valid,
  output reg  [63:0] msg_addr,
  output reg  [31:0] msg_data,
  input  wire        msg_ack,
  output reg         intx_out,
  // EEPROM agent.
  output reg         ee_req,
  output reg         ee_write,
  output reg  [5:0]  ee_addr,
  output reg  [31:0] ee_wdata,
  input  wire        ee_done,
  input  wire [31:0] ee_rdata,
  // Interrupt.
  output reg         irq
);

  // --------------------------------------------------------------------------
  // Storage.
  // --------------------------------------------------------------------------
  reg        msi_en_r;
  reg [2:0]  mme_r;
  reg [29:0] maddr_r;
  reg [31:0] muaddr_r;
  reg [15:0] mdata_r;
  reg [5:0]  pd_addr_r;
  reg        pd_flag_r;
  reg [31:0] pd_data_r;
  reg [31:0] test0_r;
  reg [`IRQ_W-1:0] irq_stat_r;
  reg [`IRQ_W-1:0] irq_mask_r;
  reg        pd_start_r;
  reg        msi_req_r;
  reg [31:0] rdata_nxt;
  reg        hit_nxt;

  wire        seq_busy;
  wire        seq_finish;
  wire [31:0] seq_rdata;
  wire        s_valid;
  wire [63:0] s_addr;
  wire [31:0] s_data;
  wire        s_intx;
  wire        s_sent;
  wire        s_ee_req;
  wire        s_ee_write;
  wire [5:0]  s_ee_addr;
  wire [31:0] s_ee_wdata;

  // --------------------------------------------------------------------------
  // Access phase decode.
  // --------------------------------------------------------------------------
  wire acc     = psel && penable && pready;
  wire wr      = acc && pwrite;
  wire rd      = acc && !pwrite;
  wire ans_cyc = psel && penable && !pready;
  wire stat_rd = rd && (paddr == `OFS_IRQ_STATUS);

  // Byte lane merge of a write.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Write data merges, cut to the width of each field.
  // --------------------------------------------------------------------------
  wire [31:0] maddr_mrg = merge({maddr_r, 2'b00}, pwdata, pstrb);
  wire [31:0] mdata_mrg = merge({16'h0000, mdata_r}, pwdata, pstrb);

  // --------------------------------------------------------------------------
  // Read decode.
  // --------------------------------------------------------------------------
  always @* begin
    rdata_nxt = `ZERO32;
    hit_nxt   = 1'b1;
    case (paddr)
      `OFS_MSG_CTRL: begin
        // [R1] Identifier and pointer.
        rdata_nxt[7:0]   = `MSI_CAP_ID;
        rdata_nxt[15:8]  = `MSI_NEXT_PTR;
        rdata_nxt[`BIT_MSI_EN] = msi_en_r;
        rdata_nxt[`MME_HI:`MME_LO] = mme_r;
        // [R4] Fixed 64-bit capable.
        rdata_nxt[`BIT_ADDR64] = 1'b1;
      end
      `OFS_MSG_ADDR:  rdata_nxt = {maddr_r, 2'b00};
      `OFS_MSG_UADDR: rdata_nxt = muaddr_r;
      `OFS_MSG_DATA:  rdata_nxt = {16'h0000, mdata_r};
      `OFS_PD_CTRL: begin
        // [R8] Header constants.
        rdata_nxt[7:0]  = `PD_CAP_ID;
        rdata_nxt[15:8] = `PD_NEXT_PTR;
        rdata_nxt[`PD_ADDR_HI:`PD_ADDR_LO] = pd_addr_r;
        rdata_nxt[`BIT_PD_FLAG] = pd_flag_r;
      end
      `OFS_PD_DATA: rdata_nxt = pd_data_r;
      `OFS_VEND_HDR: begin
        // [R14] Vendor identifier.
        rdata_nxt[7:0]   = `VEND_CAP_ID;
        // [R15] Vendor next pointer.
        rdata_nxt[15:8]  = `VEND_NEXT_PTR;
        // [R16] Vendor length.
        rdata_nxt[31:16] = `VEND_LENGTH;
      end
      `OFS_TEST0:       rdata_nxt = test0_r;
      `OFS_IRQ_STATUS:  rdata_nxt = {30'h00000000, irq_stat_r};
      `OFS_IRQ_MASK:    rdata_nxt = {30'h00000000, irq_mask_r};
      `OFS_MSI_TRIGGER: rdata_nxt = `ZERO32;
      default:          hit_nxt = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // APB handshake: one wait state, answer in the access phase.
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ZERO32;
    end else begin
      pready  <= ans_cyc;
      pslverr <= ans_cyc && !hit_nxt;
      if (ans_cyc && !pwrite) begin
        prdata <= rdata_nxt;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register writes and hardware updates.
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msi_en_r   <= 1'b0;
      mme_r      <= 3'b000;
      maddr_r    <= 30'h00000000;
      muaddr_r   <= `ZERO32;
      mdata_r    <= 16'h0000;
      pd_addr_r  <= 6'h00;
      pd_flag_r  <= 1'b0;
      pd_data_r  <= `ZERO32;
      test0_r    <= `TEST0_RESET;
      irq_mask_r <= 2'b00;
      pd_start_r <= 1'b0;
      msi_req_r  <= 1'b0;
    end else begin
      pd_start_r <= 1'b0;
      if (s_valid || s_sent) begin
        msi_req_r <= 1'b0;
      end
      if (wr) begin
        case (paddr)
          `OFS_MSG_CTRL: begin
            if (pstrb[2]) begin
              msi_en_r <= pwdata[`BIT_MSI_EN];
              // [R7] Stored and read back only, never used in messages.
              mme_r    <= pwdata[`MME_HI:`MME_LO];
            end
          end
          // [R5] Writable address bits.
          `OFS_MSG_ADDR:  maddr_r  <= maddr_mrg[31:2];
          // [R6] Writable upper half.
          `OFS_MSG_UADDR: muaddr_r <= merge(muaddr_r, pwdata, pstrb);
          `OFS_MSG_DATA:  mdata_r  <= mdata_mrg[15:0];
          `OFS_PD_CTRL: begin
            // [R12] Access ignored while busy.
            if (!seq_busy && pstrb[3]) begin
              // [R9] Table word address.
              pd_addr_r  <= pwdata[`PD_ADDR_HI:`PD_ADDR_LO];
              // [R10] [R11] Flag written starts cycle.
              pd_flag_r  <= pwdata[`BIT_PD_FLAG];
              pd_start_r <= 1'b1;
            end
          end
          // [R13] Word for writes.
          `OFS_PD_DATA: if (!seq_busy) pd_data_r <= merge(pd_data_r, pwdata, pstrb);
          // [R17] Test word.
          `OFS_TEST0:       test0_r    <= merge(test0_r, pwdata, pstrb);
          `OFS_IRQ_MASK:    irq_mask_r <= pwdata[`IRQ_W-1:0];
          `OFS_MSI_TRIGGER: if (pwdata[0]) msi_req_r <= 1'b1;
          default: ;
        endcase
      end
      if (seq_finish) begin
        // [R10] [R11] Flag toggles on completion.
        pd_flag_r <= !pd_flag_r;
        // [R13] Read data captured.
        if (!pd_flag_r) begin
          pd_data_r <= seq_rdata;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status: a read clears it, a new event in that cycle wins.
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 2'b00;
    end else begin
      irq_stat_r <= (stat_rd ? 2'b00 : irq_stat_r) | {s_sent, seq_finish};
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt output.
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // --------------------------------------------------------------------------
  // Message fabric outputs.
  // --------------------------------------------------------------------------
  // Valid falls at the edge that takes the acknowledge, so no word is offered twice.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_valid <= 1'b0;
      msg_addr  <= 64'h0000000000000000;
      msg_data  <= `ZERO32;
      intx_out  <= 1'b0;
    end else begin
      msg_valid <= s_valid && !(msg_valid && msg_ack);
      msg_addr  <= s_addr;
      msg_data  <= s_data;
      intx_out  <= s_intx;
    end
  end

  // --------------------------------------------------------------------------
  // EEPROM agent outputs.
  // --------------------------------------------------------------------------
  // Request falls at the edge that takes done, so the agent sees no second cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_req   <= 1'b0;
      ee_write <= 1'b0;
      ee_addr  <= 6'h00;
      ee_wdata <= `ZERO32;
    end else begin
      ee_req   <= s_ee_req && !(ee_req && ee_done);
      ee_write <= s_ee_write;
      ee_addr  <= s_ee_addr;
      ee_wdata <= s_ee_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Submodules.
  // --------------------------------------------------------------------------
  pd_eeprom_seq u_seq (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (pd_start_r),
    .write_op (pd_flag_r),
    .addr     (pd_addr_r),
    .wdata    (pd_data_r),
    .ee_req   (s_ee_req),
    .ee_write (s_ee_write),
    .ee_addr  (s_ee_addr),
    .ee_wdata (s_ee_wdata),
    .ee_done  (ee_done && ee_req),
    .ee_rdata (ee_rdata),
    .busy     (seq_busy),
    .finish   (seq_finish),
    .rdata    (seq_rdata)
  );

  // [R6] High half used because 64-bit capable.
  msi_sender u_msi (
    .pclk        (pclk),
    .presetn     (presetn),
    .request     (service_req || msi_req_r),
    .enable      (msi_en_r),
    .target      ({muaddr_r, maddr_r, 2'b00}),
    .payload     (mdata_r),
    .msg_valid   (s_valid),
    .msg_addr    (s_addr),
    .msg_data    (s_data),
    .msg_ack     (msg_ack && msg_valid),
    .intx_assert (s_intx),
    .sent        (s_sent)
  );

endmodule // msi_product_data_capability_header_regs

// >>> eeprom_table_model.sv
// Behavioural EEPROM agent holding the product data table.
// Assumes the bank holds ee_req until it samples a one-cycle ee_done.
`timescale 1ns/1ns
module eeprom_table_model (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // Request from the bank.
  input  wire        ee_req,
  input  wire        ee_write,
  input  wire [5:0]  ee_addr,
  input  wire [31:0] ee_wdata,
  // Answer and pacing.
  input  wire [3:0]  wait_cycles,
  output reg         ee_done,
  output reg  [31:0] ee_rdata
);
  reg [31:0] mem [0:63];
  reg [3:0]  cnt_r;
  integer    j;
  // ---------------------------------------------------------------------------
  // Table contents and answer timing.
  // ---------------------------------------------------------------------------
  initial begin
    for (j = 0; j < 64; j = j + 1) begin
      mem[j] = 32'h5A000000 + j;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 4'h0;
      ee_done  <= 1'b0;
      ee_rdata <= 32'h00000000;
    end else begin
      ee_done  <= 1'b0;
      ee_rdata <= ~ee_rdata;
      if (ee_req && !ee_done) begin
        if (cnt_r == wait_cycles) begin
          cnt_r   <= 4'h0;
          ee_done <= 1'b1;
          if (ee_write) begin
            mem[ee_addr] <= ee_wdata;
          end else begin
            ee_rdata <= mem[ee_addr];
          end
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule // eeprom_table_model

// >>> msi_vpd_props.sv
// Concurrent checks on the capability register bank ports.
// Assumes one clock domain, pclk, with presetn as its reset.
`timescale 1ns/1ns
module msi_vpd_props (
  // Clock and reset.
  input wire        pclk,
  input wire        presetn,
  // APB.
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pready,
  // Message and EEPROM sides.
  input wire        msg_valid,
  input wire [63:0] msg_addr,
  input wire [31:0] msg_data,
  input wire        msg_ack,
  input wire        intx_out,
  input wire        ee_req,
  input wire        ee_write,
  input wire [5:0]  ee_addr
);
  reg        msi_en_r;
  reg [31:0] pd_cmd_r;
  wire       wr_done = psel && penable && pready && pwrite;
  wire       rd_done = psel && penable && pready && !pwrite;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msi_en_r <= 1'b0;
      pd_cmd_r <= 32'h00000000;
    end else begin
      if (wr_done && paddr == 8'h4C && pstrb[2]) begin
        msi_en_r <= pwdata[16];
      end
      if (wr_done && paddr == 8'h5C && pstrb[3] && !ee_req) begin
        pd_cmd_r <= pwdata;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------------------
  // Properties.
  // ---------------------------------------------------------------------------
  ctrl_id_a: assert property (rd_done && paddr == 8'h4C |-> prdata[7:0] == 8'h05)
    else $error("message capability id wrong");
  addr64_ro_a: assert property (rd_done && paddr == 8'h4C |-> prdata[23])
    else $error("64-bit capable bit not set");
  no_msg_off_a: assert property ((!msi_en_r)[*4] |-> !$rose(msg_valid))
    else $error("message sent while disabled");
  legacy_quiet_a: assert property (msi_en_r[*3] |-> !intx_out)
    else $error("legacy pin used while messages enabled");
  msg_form_a: assert property (msg_valid |-> msg_addr[1:0] == 2'b00
    && msg_data[31:16] == 16'h0) else $error("message address or payload malformed");
  msg_hold_a: assert property (msg_valid && !msg_ack |=> msg_valid && $stable(msg_addr)
    && $stable(msg_data)) else $error("message dropped or changed before ack");
  pd_hdr_a: assert property (rd_done && paddr == 8'h5C |-> prdata[15:0] == 16'h6403)
    else $error("product data header wrong");
  pd_start_a: assert property (wr_done && paddr == 8'h5C && pstrb[3] && !ee_req
    |-> ##[1:3] (ee_req && ee_addr == pd_cmd_r[23:18] && ee_write == pd_cmd_r[31]))
    else $error("table cycle not started as commanded");
  vend_hdr_a: assert property (rd_done && paddr == 8'h64
    |-> prdata == 32'h0034B009) else $error("vendor header wrong");
endmodule // msi_vpd_props
bind msi_product_data_capability_header_regs msi_vpd_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .msg_valid(msg_valid), .msg_addr(msg_addr),
  .msg_data(msg_data), .msg_ack(msg_ack), .intx_out(intx_out), .ee_req(ee_req),
  .ee_write(ee_write), .ee_addr(ee_addr));

// >>> test_msi_product_data_capability_header_regs.sv
// Self-checking bench for the capability register bank.
// Assumes the EEPROM table model and the bound checker beside the design.
`timescale 1ns/1ns
module test_msi_product_data_capability_header_regs;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [3:0]  pstrb = 4'h0, ee_wait = 4'h0;
  reg         service_req = 1'b0, msg_ack = 1'b0, er;
  wire [31:0] prdata, ee_wdata, ee_rdata, msg_data;
  wire [63:0] msg_addr;
  wire [5:0]  ee_addr;
  wire        pready, pslverr, msg_valid, intx_out, ee_req, ee_write, ee_done, irq;
  wire [1:0]  ev = {irq, msg_valid};
  integer     miscompares = 0, total_checks = 0, i;
  reg  [31:0] rd, wd [0:5], we [0:5];
  reg  [7:0]  wa [0:5];
  always #50 pclk = ~pclk;
  msi_product_data_capability_header_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .service_req(service_req), .msg_valid(msg_valid),
    .msg_addr(msg_addr), .msg_data(msg_data), .msg_ack(msg_ack), .intx_out(intx_out),
    .ee_req(ee_req), .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
    .ee_done(ee_done), .ee_rdata(ee_rdata), .irq(irq));
  eeprom_table_model table_model (.pclk(pclk), .presetn(presetn), .ee_req(ee_req),
    .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .wait_cycles(ee_wait),
    .ee_done(ee_done), .ee_rdata(ee_rdata));
  // ---------------------------------------------------------------------------
  // Bus, compare and closing tasks.
  // ---------------------------------------------------------------------------
  task give_verdict;
    begin
      if (miscompares == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task bound(input integer cnt, input integer lim);
    begin
      if (cnt >= lim) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: wait timed out", $time);
        give_verdict;
      end
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    integer k;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
        k = k + 1;
        @(posedge pclk);
      end
      bound(k, 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task await(input integer b);
    integer k;
    begin
      k = 0;
      while (ev[b] !== 1'b1 && k < 30) begin
        k = k + 1;
        @(posedge pclk);
      end
      bound(k, 30);
    end
  endtask
  task poll(input [31:0] fin);
    integer k;
    begin
      k = 0;
      xfer(1'b0, 8'h5C, 32'h0, 4'h0);
      while (rd[31] !== fin[31] && k < 40) begin
        k = k + 1;
        xfer(1'b0, 8'h5C, 32'h0, 4'h0);
      end
      bound(k, 40);
      check(rd, fin);
    end
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    wa = '{8'h4C, 8'h50, 8'h54, 8'h58, 8'h64, 8'h68};
    wd = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h89ABCDEF, 32'hFFFFFFFF, 32'h0, 32'h12345678};
    we = '{32'h00806405, 32'h0, 32'h0, 32'h0, 32'h0034B009, 32'h04001060};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 8'h5C, 32'h0, 4'h0);
    check(rd, 32'h00006403);
    for (i = 0; i < 6; i = i + 1) begin
      xfer(1'b0, wa[i], 32'h0, 4'h0);
      check(rd, we[i]);
    end
    we = '{32'h00F16405, 32'hFFFFFFFC, 32'h89ABCDEF, 32'h0000FFFF, 32'h0034B009, 32'h12345678};
    for (i = 0; i < 6; i = i + 1) begin
      xfer(1'b1, wa[i], wd[i], 4'hF);
      xfer(1'b0, wa[i], 32'h0, 4'h0);
      check(rd, we[i]);
    end
    xfer(1'b0, 8'h70, 32'h0, 4'h0);
    check(rd, 32'h00000000);
    check({31'b0, er}, 32'h00000001);
    xfer(1'b1, 8'h84, 32'h3, 4'hF);
    service_req <= 1'b1;
    await(0);
    service_req <= 1'b0;
    check(msg_addr[31:0], 32'hFFFFFFFC);
    check(msg_addr[63:32], 32'h89ABCDEF);
    check(msg_data, 32'h0000FFFF);
    check({31'b0, intx_out}, 32'h0);
    @(posedge pclk);
    msg_ack <= 1'b1;
    @(posedge pclk);
    msg_ack <= 1'b0;
    await(1);
    xfer(1'b0, 8'h80, 32'h0, 4'h0);
    check(rd, 32'h2);
    @(posedge pclk);
    check({31'b0, irq}, 32'h0);
    xfer(1'b1, 8'h4C, 32'h0, 4'h4);
    service_req <= 1'b1;
    repeat (6) @(posedge pclk);
    check({30'b0, msg_valid, intx_out}, 32'h1);
    service_req <= 1'b0;
    xfer(1'b1, 8'h60, 32'hDEADBEEF, 4'hF);
    xfer(1'b1, 8'h5C, 32'h80140000, 4'hC);
    poll(32'h00146403);
    await(1);
    xfer(1'b0, 8'h80, 32'h0, 4'h0);
    check(rd, 32'h1);
    ee_wait <= 4'h7;
    xfer(1'b1, 8'h5C, 32'h00140000, 4'hC);
    poll(32'h80146403);
    xfer(1'b0, 8'h60, 32'h0, 4'h0);
    check(rd, 32'hDEADBEEF);
    xfer(1'b1, 8'h5C, 32'h00FC0000, 4'hC);
    poll(32'h80FC6403);
    xfer(1'b0, 8'h60, 32'h0, 4'h0);
    check(rd, 32'h5A00003F);
    xfer(1'b1, 8'h4C, 32'h00010000, 4'h4);
    xfer(1'b1, 8'h88, 32'h00000001, 4'hF);
    await(0);
    check(msg_data, 32'h0000FFFF);
    check({31'b0, intx_out}, 32'h0);
    give_verdict;
  end
endmodule // test_msi_product_data_capability_header_regs
